/* File: qsp_cfg.svh */
// Contract
// (RQ1) write starts on k rise with write select low; here a full write buffer refuses the write instead
// (RQ2) write words arrive on edges of t+1, t+2
// (RQ3) read starts on k rise with read select low
// (RQ4) read words leave on edges of t+2, t+3
// (RQ5) burst walks a, a+1, a+2, a+3
// (RQ6) powers up deselected, read bus released
// (RQ7) controller parks both clocks high when stopped
// (RQ8) same-type request on next k rise ignored
// (RQ9) controller spaces same-type requests two cycles apart
// (RQ10) select used last cycle is don't-care now
// (RQ11) narrow width: two lanes gate 8:0, 17:9
// (RQ12) wide width: four lanes gate nine-bit bytes
// (RQ13) lane enables sampled with every data word
// (RQ14) deselected read port finishes, then releases bus
// (RQ15) both selects low alternate, read first
// (RQ16) both selects high start nothing
`ifndef QSP_CFG_SVH
`define QSP_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define QSP_DW 36
`define QSP_AW 10
`define QSP_LANES 4
`define QSP_LANE_W 9
`define QSP_FIFO_DEPTH 32

// ----------------------------------------------------------------
// burst timing, in pre-shift pipeline positions counted in edges
// ----------------------------------------------------------------
`define QSP_WR_FIRST 1
`define QSP_WR_LAST 4
`define QSP_RD_FIRST 3
`define QSP_RD_LAST 6
`define QSP_BURST 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
// clocks parked high, both selects high (deselected)
`define QSP_PIN_RST 55'h78000000000000

`endif

/* File: qsp_pkg.sv */
package qsp_pkg;

   // ----------------------------------------------------------------
   // read prefetch state, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      QSP_F_IDLE = 2'b01, // nothing to fetch
      QSP_F_BUSY = 2'b10  // pulling four words out of the array
   } qsp_fetch_e;

   typedef logic [3:0] qsp_lane_t; // one bit per nine-bit byte

endpackage : qsp_pkg

/* File: qsp_fifo.sv */
`timescale 1ns/10ps
module qsp_fifo #(
   parameter int W = 50,    // word width
   parameter int DEPTH = 32 // words held
) (
   input wire logic clk,           // system clock
   input wire logic reset,         // async, active high
   input wire logic in_valid,      // word offered
   output logic in_ready,          // room for a word
   input wire logic [W-1:0] in_data, // word in
   output logic out_valid,         // word waiting
   input wire logic out_ready,     // drain takes it
   output logic [W-1:0] out_data   // oldest word
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] store [0:DEPTH-1]; // word storage
   logic [PW-1:0] wr_ptr_q; // next free slot
   logic [PW-1:0] rd_ptr_q; // oldest slot
   logic [PW:0] count_q; // words held
   logic push; // accepted write
   logic pop; // accepted read

   assign in_ready = (count_q != (PW + 1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = store[rd_ptr_q];

   // ----------------------------------------------------------------
   // storage, no reset: content is meaningless until counted
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr_q] <= in_data;
      end
   end

   // pointers wrap naturally, depth is a power of two
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push & ~pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule : qsp_fifo

/* File: qsp_port.sv */
`timescale 1ns/10ps
`include "qsp_cfg.svh"
module qsp_port (
   input wire logic clk,                    // 50 MHz system clock
   input wire logic reset,                  // async, active high
   input wire logic main_timing_pos,        // k clock pin
   input wire logic main_timing_neg,        // k-bar clock pin
   input wire logic read_select_n,          // read port select
   input wire logic write_select_n,         // write port select
   input wire logic [9:0] addr_in,          // shared burst address
   input wire logic [35:0] wr_bus_in,       // write data pins
   input wire logic [3:0] lane_write_enable_n, // byte write lanes
   input wire logic wide_mode,              // 1: 36-bit, 0: 18-bit
   output logic [35:0] read_out_bus,        // read data pins
   output logic read_out_oe,                // read bus driven
   output logic write_stall                 // write buffer full
);
   localparam int AW = `QSP_AW;
   localparam int DW = `QSP_DW;
   localparam int NL = `QSP_LANES;
   localparam int LW = `QSP_LANE_W;
   localparam int WF = `QSP_WR_FIRST;
   localparam int WL = `QSP_WR_LAST;
   localparam int RF = `QSP_RD_FIRST;
   localparam int RL = `QSP_RD_LAST;
   localparam int PINW = 55;
   localparam int QW = NL + AW + DW; // buffered write entry

   // ----------------------------------------------------------------
   // lane decode
   // ----------------------------------------------------------------
   // narrow width only has the two low lanes; upper ones read as off
   function automatic qsp_pkg::qsp_lane_t lane_en(
      input logic [3:0] lanes_n,
      input logic wide
   );
      lane_en = wide ? ~lanes_n : {2'b00, ~lanes_n[1:0]};
   endfunction : lane_en

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [PINW-1:0] pin_raw; // all pins as one bundle
   logic [PINW-1:0] pin_s1_q; // first stage, read only by second
   logic [PINW-1:0] pin_s2_q; // settled copy
   logic k_s3_q; // delayed k for edge detect
   logic kn_s3_q; // delayed k-bar for edge detect

   assign pin_raw = {main_timing_pos, main_timing_neg, read_select_n,
                     write_select_n, wide_mode, lane_write_enable_n,
                     addr_in, wr_bus_in};

   // two flops on everything so clocks and data stay aligned
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_s1_q <= `QSP_PIN_RST;
         pin_s2_q <= `QSP_PIN_RST;
         k_s3_q <= 1'b1;
         kn_s3_q <= 1'b1;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         k_s3_q <= pin_s2_q[54];
         kn_s3_q <= pin_s2_q[53];
      end
   end

   logic rsel_n_s; // read select, synced
   logic wsel_n_s; // write select, synced
   logic wide_s; // width strap, synced
   logic [3:0] lanes_s; // lane enables, synced
   logic [AW-1:0] addr_s; // address, synced
   logic [DW-1:0] data_s; // write data, synced
   logic pos_rise; // k rising edge seen
   logic neg_rise; // k-bar rising edge seen
   logic any_edge; // either data edge

   assign rsel_n_s = pin_s2_q[52];
   assign wsel_n_s = pin_s2_q[51];
   assign wide_s = pin_s2_q[50];
   assign lanes_s = pin_s2_q[49:46];
   assign addr_s = pin_s2_q[45:36];
   assign data_s = pin_s2_q[35:0];
   assign pos_rise = pin_s2_q[54] & ~k_s3_q;
   assign neg_rise = pin_s2_q[53] & ~kn_s3_q;
   assign any_edge = pos_rise | neg_rise;

   // ----------------------------------------------------------------
   // start arbitration
   // ----------------------------------------------------------------
   logic last_rd_q; // read started on previous k rise
   logic last_wr_q; // write started on previous k rise
   logic rd_go; // read starts now
   logic wr_go; // write starts now
   logic fifo_in_ready; // write buffer has room

   // a select used last cycle is masked, so back-to-back same-type
   // requests drop and both-low alternates starting with read
   assign rd_go = pos_rise & ~rsel_n_s & ~last_rd_q; // see (RQ3) (RQ8)
   // read wins a tie unless it started last cycle; a full buffer
   // refuses new writes rather than losing words mid-burst
   assign wr_go = pos_rise & ~wsel_n_s & ~last_wr_q & ~rd_go
                  & fifo_in_ready; // see (RQ1) (RQ10) (RQ15) (RQ16)

   // history of the previous k rise only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         last_rd_q <= 1'b0; // see (RQ6)
         last_wr_q <= 1'b0;
      end else if (pos_rise) begin
         last_rd_q <= rd_go; // see (RQ8)
         last_wr_q <= wr_go;
      end
   end

   // ----------------------------------------------------------------
   // edge pipelines: one position per data edge
   // ----------------------------------------------------------------
   logic [WL:0] wv_q; // write burst in flight
   logic [AW-1:0] wa_q [0:WL]; // its start address
   logic [RL:0] rv_q; // read burst in flight
   logic [RL:0] rs_q; // its output buffer slot
   logic slot_q; // next free output slot

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wv_q <= '0;
         rv_q <= '0;
         rs_q <= '0;
         slot_q <= 1'b0;
      end else if (any_edge) begin
         wv_q <= {wv_q[WL-1:0], wr_go};
         rv_q <= {rv_q[RL-1:0], rd_go};
         rs_q <= {rs_q[RL-1:0], slot_q};
         if (rd_go) begin
            slot_q <= ~slot_q; // two slots let bursts overlap
         end
      end
   end

   // address rides along with its burst
   genvar gi;
   generate
      for (gi = 0; gi <= WL; gi++) begin : g_wa
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               wa_q[gi] <= '0;
            end else if (any_edge) begin
               wa_q[gi] <= (gi == 0) ? addr_s : wa_q[(gi == 0) ? 0 : gi - 1];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // write data capture
   // ----------------------------------------------------------------
   logic cap_hit; // a data edge of a write burst
   logic [AW-1:0] cap_idx; // array word for this edge
   qsp_pkg::qsp_lane_t cap_en; // lanes to write
   logic push_v; // entry offered to buffer

   // at most one burst sits in the data positions at a time
   always_comb begin
      cap_hit = 1'b0;
      cap_idx = '0;
      for (int s = WF; s <= WL; s++) begin
         if (any_edge && wv_q[s]) begin // see (RQ2)
            cap_hit = 1'b1;
            cap_idx = wa_q[s] + AW'(s - WF); // see (RQ5)
         end
      end
   end

   // lanes taken fresh on every word
   assign cap_en = lane_en(lanes_s, wide_s); // see (RQ11) (RQ12) (RQ13)
   // all lanes off writes nothing, so skip the entry entirely
   assign push_v = cap_hit & (|cap_en); // see (RQ11) (RQ12)

   // ----------------------------------------------------------------
   // write buffer and array
   // ----------------------------------------------------------------
   logic drain_v; // buffered word waiting
   logic drain_rdy; // array free to take it
   logic [QW-1:0] drain_w; // buffered entry
   qsp_pkg::qsp_fetch_e fetch_q; // prefetch state
   logic mem_rd; // array read strobe
   logic [AW-1:0] mem_rd_idx; // array read word
   logic [DW-1:0] mem_q; // registered array read

   qsp_fifo #(.W(QW), .DEPTH(`QSP_FIFO_DEPTH)) u_wbuf (
      .clk(clk),
      .reset(reset),
      .in_valid(push_v),
      .in_ready(fifo_in_ready),
      .in_data({cap_en, cap_idx, data_s}),
      .out_valid(drain_v),
      .out_ready(drain_rdy),
      .out_data(drain_w)
   );

   // reads own the array while prefetching; writes wait their turn
   assign drain_rdy = (fetch_q == qsp_pkg::QSP_F_IDLE);

   // one nine-bit array per lane keeps byte writes independent
   generate
      for (gi = 0; gi < NL; gi++) begin : g_lane
         logic [LW-1:0] lane_mem [0:(1 << AW) - 1];
         always_ff @(posedge clk) begin
            if (drain_v && drain_rdy && drain_w[DW + AW + gi]) begin
               lane_mem[drain_w[DW +: AW]] <= drain_w[gi * LW +: LW];
            end
            if (mem_rd) begin
               mem_q[gi * LW +: LW] <= lane_mem[mem_rd_idx];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // read prefetch into output slots
   // ----------------------------------------------------------------
   logic [AW-1:0] fa_q; // burst start address
   logic fslot_q; // slot being filled
   logic [1:0] fcnt_q; // word being fetched
   logic ret_q; // array data returns this cycle
   logic [1:0] ret_word_q; // its word index
   logic ret_slot_q; // its slot
   logic [DW-1:0] obuf_q [0:1][0:3]; // two bursts of four words

   assign mem_rd = (fetch_q == qsp_pkg::QSP_F_BUSY);
   assign mem_rd_idx = fa_q + AW'(fcnt_q); // see (RQ5)

   // fetch runs far ahead of the first output edge (k is slow here)
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fetch_q <= qsp_pkg::QSP_F_IDLE;
         fa_q <= '0;
         fslot_q <= 1'b0;
         fcnt_q <= '0;
      end else begin
         case (fetch_q)
            qsp_pkg::QSP_F_IDLE: begin
               if (rd_go) begin // see (RQ3)
                  fa_q <= addr_s;
                  fslot_q <= slot_q;
                  fcnt_q <= '0;
                  fetch_q <= qsp_pkg::QSP_F_BUSY;
               end
            end
            qsp_pkg::QSP_F_BUSY: begin
               fcnt_q <= fcnt_q + 1'b1;
               if (fcnt_q == 2'(`QSP_BURST - 1)) begin
                  fetch_q <= qsp_pkg::QSP_F_IDLE;
               end
            end
            default: begin
               fetch_q <= qsp_pkg::QSP_F_IDLE;
            end
         endcase
      end
   end

   // registered read lands one clock later
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ret_q <= 1'b0;
         ret_word_q <= '0;
         ret_slot_q <= 1'b0;
      end else begin
         ret_q <= mem_rd;
         ret_word_q <= fcnt_q;
         ret_slot_q <= fslot_q;
      end
   end

   // output slot storage, datapath only
   always_ff @(posedge clk) begin
      if (ret_q) begin
         obuf_q[ret_slot_q][ret_word_q] <= mem_q;
      end
   end

   // ----------------------------------------------------------------
   // read output drive
   // ----------------------------------------------------------------
   logic out_hit; // an output edge of a read burst
   logic [DW-1:0] out_word; // word for this edge

   always_comb begin
      out_hit = 1'b0;
      out_word = '0;
      for (int s = RF; s <= RL; s++) begin
         if (any_edge && rv_q[s]) begin // see (RQ4)
            out_hit = 1'b1;
            out_word = obuf_q[rs_q[s]][s - RF]; // see (RQ5)
         end
      end
   end

   // bus released on the first k rise with no word left to send
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         read_out_bus <= '0;
         read_out_oe <= 1'b0; // see (RQ6)
      end else if (out_hit) begin
         read_out_bus <= out_word; // see (RQ4)
         read_out_oe <= 1'b1;
      end else if (pos_rise) begin
         read_out_oe <= 1'b0; // see (RQ14)
      end
   end

   // full buffer shows so the outside can see refused writes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         write_stall <= 1'b0;
      end else begin
         write_stall <= ~fifo_in_ready;
      end
   end

endmodule : qsp_port

/* File: qsp_port_properties.sv */
`timescale 1ns/10ps
module qsp_chk (
   input wire logic clk, // system clock
   input wire logic reset, // async, active high
   input wire logic main_timing_pos, // k pin
   input wire logic main_timing_neg, // k-bar pin
   input wire logic read_select_n, // read select
   input wire logic write_select_n, // write select
   input wire logic [9:0] addr_in, // address pins
   input wire logic [35:0] wr_bus_in, // write data
   input wire logic [3:0] lane_write_enable_n, // byte lanes
   input wire logic wide_mode, // width select
   input wire logic [35:0] read_out_bus, // read data
   input wire logic read_out_oe, // read bus driven
   input wire logic write_stall // buffer full
);
   // ----------------------------------------------------------------
   // helper state
   // ----------------------------------------------------------------
   logic kp_q; // k pin one clk ago
   logic kn_q; // k-bar pin one clk ago
   logic k_rise; // k pin rose before this clk
   logic kn_rise; // k-bar pin rose before this clk
   logic [4:0] rd_hist_q; // read starts per k rise, newest in bit 0
   logic [3:0] since_q; // clks since a k rise, saturating
   logic [3:0] sincen_q; // clks since a k-bar rise, saturating

   assign k_rise = main_timing_pos && !kp_q;
   assign kn_rise = main_timing_neg && !kn_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // pin copies; parked high so release of reset shows no rise
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         kp_q <= 1'b1;
         kn_q <= 1'b1;
      end else begin
         kp_q <= main_timing_pos;
         kn_q <= main_timing_neg;
      end
   end

   // reads the device must take: one right after a read is void
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_hist_q <= 5'h00;
      end else if (k_rise) begin
         rd_hist_q <= {rd_hist_q[3:0], !read_select_n && !rd_hist_q[0]};
      end
   end

   // distance to the last rise of each clock pin
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         since_q <= 4'hf;
         sincen_q <= 4'hf;
      end else begin
         since_q <= k_rise ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
         sincen_q <= kn_rise ? 4'h0 : sincen_q + {3'h0, sincen_q != 4'hf};
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   chk_reset_quiet: assert property (
      $fell(reset) |-> !read_out_oe && !write_stall && read_out_bus == 36'h0)
      else $error("outputs not quiet after reset");
   chk_oe_cause: assert property (
      read_out_oe |-> |rd_hist_q[4:2])
      else $error("read bus driven without a read");
   chk_oe_open: assert property (
      k_rise && rd_hist_q[1] |-> ##[1:7] read_out_oe)
      else $error("read bus not driven two cycles after read");
   chk_oe_release: assert property (
      k_rise && read_out_oe && !rd_hist_q[1] && !rd_hist_q[2]
      |-> ##[1:7] !read_out_oe)
      else $error("read bus not released after burst");
   chk_oe_quiet: assert property (
      k_rise && !read_out_oe && !rd_hist_q[1] |-> !read_out_oe [*8])
      else $error("read bus driven with nothing pending");
   chk_oe_steady: assert property (
      $rose(read_out_oe) |-> read_out_oe [*8])
      else $error("read bus dropped inside burst");
   chk_bus_on_edge: assert property (
      !$stable(read_out_bus)
      |-> since_q inside {[1:6]} || sincen_q inside {[1:6]})
      else $error("read data moved away from a clock rise");
   chk_oe_on_k: assert property (
      !$stable(read_out_oe) |-> since_q inside {[1:6]})
      else $error("read enable moved away from a k rise");
endmodule : qsp_chk

bind qsp_port qsp_chk chk (.clk(clk), .reset(reset),
   .main_timing_pos(main_timing_pos), .main_timing_neg(main_timing_neg),
   .read_select_n(read_select_n), .write_select_n(write_select_n),
   .addr_in(addr_in), .wr_bus_in(wr_bus_in),
   .lane_write_enable_n(lane_write_enable_n), .wide_mode(wide_mode),
   .read_out_bus(read_out_bus), .read_out_oe(read_out_oe),
   .write_stall(write_stall));

/* File: qsp_ctrl_model.sv */
`timescale 1ns/10ps
module qsp_ctrl_model (
   input wire logic clk, // system clock
   input wire logic [35:0] q_in, // device read data
   input wire logic oe_in, // device drives read data
   output logic k_pos, // k clock
   output logic k_neg, // k-bar clock
   output logic rs_n, // read select
   output logic ws_n, // write select
   output logic [9:0] addr, // burst address
   output logic [35:0] d, // write data
   output logic [3:0] lanes_n // byte lanes
);
   logic [35:0] qk; // word seen after k rise
   logic [35:0] qkb; // word seen after k-bar rise
   logic oek; // read bus driven after k rise

   // clocks parked high until the first cycle
   initial begin
      k_pos = 1'b1;
      k_neg = 1'b1;
      rs_n = 1'b1;
      ws_n = 1'b1;
      addr = 10'h000;
      d = 36'h0;
      lanes_n = 4'hf;
   end

   // ----------------------------------------------------------------
   // one k cycle; pins move on falling clk, well clear of both rises
   // ----------------------------------------------------------------
   task kcycle(input logic rs, input logic ws, input logic [9:0] a,
      input logic dv, input logic [35:0] dk, input logic [35:0] dkb,
      input logic [3:0] lk, input logic [3:0] lkb);
      @(negedge clk);
      k_pos = 1'b0;
      k_neg = 1'b1;
      rs_n = rs;
      ws_n = ws;
      addr = a;
      d = dv ? dk : ~d;
      lanes_n = dv ? lk : 4'hf;
      repeat (4) @(negedge clk);
      k_pos = 1'b1;
      k_neg = 1'b0;
      repeat (6) @(negedge clk);
      // a released bus floats: show the inverse of the held word
      qk = oe_in ? q_in : ~q_in;
      oek = oe_in;
      repeat (2) @(negedge clk);
      // hold time over: lines stop showing the old value
      rs_n = ~rs_n;
      ws_n = ~ws_n;
      addr = ~addr;
      d = dv ? dkb : ~d;
      lanes_n = dv ? lkb : 4'hf;
      repeat (2) @(negedge clk);
      k_pos = 1'b0;
      k_neg = 1'b1;
      repeat (6) @(negedge clk);
      qkb = oe_in ? q_in : ~q_in;
   endtask : kcycle

   // stop the clocks with both parked high
   task park;
      @(negedge clk);
      rs_n = 1'b1;
      ws_n = 1'b1;
      k_pos = 1'b1;
      k_neg = 1'b1;
   endtask : park
endmodule : qsp_ctrl_model

/* File: qsp_port_tb.sv */
`timescale 1ns/10ps
module qsp_port_tb;
   logic clk, reset, wide, k_pos, k_neg, rs_n, ws_n, oe, stall; // pins
   logic [9:0] addr; // burst address
   logic [35:0] d, q; // data pins
   logic [3:0] lanes_n; // byte lanes
   logic [35:0] mem [1024]; // expected array content
   logic [35:0] wd [4]; // burst words
   logic [3:0] wl [4]; // burst lanes
   int error_cnt, compares;

   qsp_port dut (.clk(clk), .reset(reset), .main_timing_pos(k_pos),
      .main_timing_neg(k_neg), .read_select_n(rs_n),
      .write_select_n(ws_n), .addr_in(addr), .wr_bus_in(d),
      .lane_write_enable_n(lanes_n), .wide_mode(wide),
      .read_out_bus(q), .read_out_oe(oe), .write_stall(stall));
   qsp_ctrl_model m (.clk(clk), .q_in(q), .oe_in(oe), .k_pos(k_pos),
      .k_neg(k_neg), .rs_n(rs_n), .ws_n(ws_n), .addr(addr), .d(d),
      .lanes_n(lanes_n));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task chk(input logic [35:0] seen, input logic [35:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   task fillw(input logic [35:0] base, input logic [15:0] ln);
      for (int i = 0; i < 4; i++) begin
         wd[i] = base ^ {4{9'(i + 1)}};
         wl[i] = ln[i*4 +: 4];
      end
   endtask : fillw

   // merge a burst into the expected array, address wraps
   task upd(input logic [9:0] a);
      logic [9:0] w;
      for (int i = 0; i < 4; i++) begin
         w = a + 10'(i);
         for (int j = 0; j < 4; j++) begin
            if (!wl[i][j] && (wide || j < 2)) begin
               mem[w][j*9 +: 9] = wd[i][j*9 +: 9];
            end
         end
      end
   endtask : upd

   task idle;
      m.kcycle(1'b1, 1'b1, 10'h0, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
   endtask : idle

   task setw(input logic w);
      @(negedge clk);
      wide = w;
      repeat (4) @(negedge clk);
   endtask : setw

   // dup repeats the request on the next k rise
   task wr(input logic [9:0] a, input logic dup);
      m.kcycle(1'b1, 1'b0, a, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      m.kcycle(1'b1, !dup, a + 10'h8, 1'b1, wd[0], wd[1], wl[0], wl[1]);
      m.kcycle(1'b1, 1'b1, 10'h0, 1'b1, wd[2], wd[3], wl[2], wl[3]);
      upd(a);
   endtask : wr

   task rd(input logic [9:0] a, input logic dup);
      logic [35:0] msk;
      msk = wide ? 36'hfffffffff : 36'h00003ffff;
      m.kcycle(1'b0, 1'b1, a, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      m.kcycle(!dup, 1'b1, a + 10'h5, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      chk({35'h0, m.oek}, 36'h0);
      for (int i = 0; i < 4; i += 2) begin
         idle();
         chk({35'h0, m.oek}, 36'h1);
         chk(m.qk & msk, mem[a + 10'(i)] & msk);
         chk(m.qkb & msk, mem[a + 10'(i + 1)] & msk);
      end
      idle();
      chk({35'h0, m.oek}, 36'h0);
   endtask : rd

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      chk(q, 36'h0);
      chk({34'h0, oe, stall}, 36'h0);
      idle();
      chk({35'h0, m.oek}, 36'h0);
   endtask : t_reset

   task t_burst;
      fillw(36'h123456789, 16'h0000);
      wr(10'h3fe, 1'b0);
      rd(10'h3fe, 1'b0);
   endtask : t_burst

   task t_both;
      fillw(36'h3c3c3c3c3, 16'h0000);
      m.kcycle(1'b0, 1'b0, 10'h3fe, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      m.kcycle(1'b0, 1'b0, 10'h060, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      m.kcycle(1'b1, 1'b1, 10'h0, 1'b1, wd[0], wd[1], wl[0], wl[1]);
      chk(m.qk, mem[10'h3fe]);
      m.kcycle(1'b1, 1'b1, 10'h0, 1'b1, wd[2], wd[3], wl[2], wl[3]);
      chk(m.qk, mem[10'h000]);
      upd(10'h060);
      rd(10'h060, 1'b0);
   endtask : t_both

   task t_ignore;
      fillw(36'h0f0f0f0f0, 16'h0000);
      wr(10'h048, 1'b0);
      fillw(36'h5a5a5a5a5, 16'h0000);
      wr(10'h040, 1'b1);
      rd(10'h048, 1'b0);
      rd(10'h040, 1'b1);
   endtask : t_ignore

   task t_lanes;
      fillw(36'h000000000, 16'h0000);
      wr(10'h020, 1'b0);
      fillw(36'hfedcba987, 16'hbf7e); // lanes change word by word
      wr(10'h020, 1'b0);
      rd(10'h020, 1'b0);
      setw(1'b0);
      fillw(36'h111111111, 16'h0000);
      wr(10'h030, 1'b0);
      fillw(36'h2468ace02, 16'h3c6d); // upper lanes must not matter
      wr(10'h030, 1'b0);
      rd(10'h030, 1'b0);
      setw(1'b1);
   endtask : t_lanes

   // write buffer seen through the top: drains between bursts, never full
   task t_fifo;
      fillw(36'h0a50a50a5, 16'h0000);
      wr(10'h100, 1'b0);
      chk({35'h0, stall}, 36'h0);
      wr(10'h104, 1'b0);
      chk({35'h0, stall}, 36'h0);
      rd(10'h100, 1'b0);
      rd(10'h104, 1'b0);
   endtask : t_fifo

   // ----------------------------------------------------------------
   // clock, sequence, hang guard
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      reset = 1'b1;
      wide = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_burst();
      t_both();
      t_ignore();
      t_lanes();
      t_fifo();
      m.park();
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      summarize();
   end
endmodule : qsp_port_tb
